// ==== pkg/rio_consts.vh ====
`ifndef RIO_CONSTS_VH
`define RIO_CONSTS_VH
`define RIO_AREA_P       8'hF0
`define RIO_AREA_Q       8'hF1
`define RIO_AREA_X3      8'hFC
`define RIO_AREA_X4      8'hFD
`define RIO_PAGE_SEL_OFS 8'hFF
`define RIO_NOTRDY_BIT   6
`define RIO_CFG_MIN_MS   5000
`define RIO_CFG_MAX_MS   20000
`define RIO_CLK_KHZ      25000
`define RIO_FLASH_BASE   24'h000FFF
`define RIO_ACK_DLY      2'h1
`endif

// ==== verilog/rio_flasher.v ====
`timescale 1ns/10ps
`include "rio_consts.vh"
module rio_flasher #(
	parameter BASE = 24'h000FFF
) (
	pclk,
	presetn,
	baud_sel,
	run,
	led
);
	input        pclk;
	input        presetn;
	input  [1:0] baud_sel;
	input        run;
	output       led;
	reg    [23:0] cnt_q;
	reg           led_q;
	wire   [23:0] lim;
	assign lim = BASE << baud_sel;
	assign led = led_q;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= 24'h000000;
			led_q <= 1'b0;
		end else if (!run) begin
			cnt_q <= 24'h000000;
			led_q <= 1'b0;
		end else if (cnt_q >= lim) begin
			cnt_q <= 24'h000000;
			led_q <= ~led_q;
		end else begin
			cnt_q <= cnt_q + 24'h000001;
		end
	end
endmodule // rio_flasher

// ==== verilog/rio_chain.v ====
`timescale 1ns/10ps
module rio_chain (
	pclk,
	presetn,
	enable,
	term_ok,
	active,
	led,
	fault
);
	input  pclk;
	input  presetn;
	input  enable;
	input  term_ok;
	input  active;
	output led;
	output fault;
	reg    led_q;
	reg    fault_q;
	assign led = led_q;
	assign fault = fault_q;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			led_q   <= 1'b0;
			fault_q <= 1'b0;
		end else begin
			led_q   <= enable;
			fault_q <= enable & ~term_ok & active;
		end
	end
endmodule // rio_chain

// ==== verilog/rio_top.v ====
`timescale 1ns/10ps
`include "rio_consts.vh"
module rio_top #(
	parameter CFG_CYC  = 125000000,
	parameter PAGE_EN  = 1'b0
) (
	pclk,
	presetn,
	psel,
	penable,
	pwrite,
	paddr,
	pwdata,
	prdata,
	pready,
	pslverr,
	indirect_op,
	page_area_sel,
	diag_addr_sel,
	baud_sel,
	mode_on,
	ack_timeout_mode,
	chain_en,
	chain_term_ok,
	self_test_fail,
	mod_present,
	chain_tx,
	chain_active,
	red_led,
	green_led,
	chain_fault,
	cfg_done
);
	input         pclk;
	input         presetn;
	input         psel;
	input         penable;
	input         pwrite;
	input  [31:0] paddr;
	input  [31:0] pwdata;
	output [31:0] prdata;
	output        pready;
	output        pslverr;
	input         indirect_op;
	input  [5:0]  page_area_sel;
	input  [7:0]  diag_addr_sel;
	input  [1:0]  baud_sel;
	input         mode_on;
	input         ack_timeout_mode;
	input  [1:0]  chain_en;
	input  [1:0]  chain_term_ok;
	input         self_test_fail;
	input         mod_present;
	output [7:0]  chain_tx;
	output [1:0]  chain_active;
	output        red_led;
	output [1:0]  green_led;
	output [1:0]  chain_fault;
	output        cfg_done;

	localparam ST_CFG  = 2'h0;
	localparam ST_RUN  = 2'h1;
	localparam ST_FAIL = 2'h2;

	reg  [7:0]  in_mem  [0:2047];
	reg  [7:0]  out_mem [0:2047];
	reg  [1:0]  st_q;
	reg  [31:0] cyc_q;
	reg  [1:0]  page_q;
	reg  [31:0] prdata_q;
	reg         pready_q;
	reg         pslverr_q;
	reg  [1:0]  wait_q;
	reg  [7:0]  tx_q;
	reg  [1:0]  act_q;
	reg         done_q;
	reg  [10:0] idx;
	reg         hit;
	reg         resv;
	reg         diag;
	reg         psel_pg;
	wire [7:0]  hi;
	wire [7:0]  lo;
	wire        run_led;
	wire        no_link;
	wire        ack_ok;

	assign hi = paddr[15:8];
	assign lo = paddr[7:0];
	assign prdata  = prdata_q;
	assign pready  = pready_q;
	assign pslverr = pslverr_q;
	assign chain_tx = tx_q;
	assign chain_active = act_q;
	assign cfg_done = done_q;

	// area decode; extended areas only on indirect ops
	always @* begin
		hit = 1'b0;
		resv = 1'b0;
		diag = 1'b0;
		psel_pg = 1'b0;
		idx = 11'h000;
		if (hi == `RIO_AREA_P) begin
			hit = 1'b1;
			diag = (lo == diag_addr_sel);
			idx = {3'h0, lo};
		end else if (hi == `RIO_AREA_Q) begin
			hit = 1'b1;
			if (PAGE_EN) begin
				psel_pg = (lo == `RIO_PAGE_SEL_OFS);
				idx = {1'b1, page_q, lo};
			end else begin
				idx = {3'h1, lo};
			end
		end else if ((hi == `RIO_AREA_X3) && indirect_op) begin
			hit = 1'b1;
			idx = {3'h2, lo};
		end else if ((hi == `RIO_AREA_X4) && indirect_op) begin
			hit = 1'b1;
			idx = {3'h3, lo};
		end
		if (PAGE_EN && (hi == `RIO_AREA_P) && diag &&
			(paddr[29:24] != page_area_sel)) begin
			diag = 1'b0;
		end
		resv = diag | psel_pg;
	end

	assign no_link = |(chain_en & ~chain_term_ok);
	assign ack_ok = (st_q == ST_RUN) &&
		!(ack_timeout_mode && !mode_on) &&
		!no_link &&
		(!ack_timeout_mode || mod_present || resv);

	// configuration run independent of host state
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q <= ST_CFG;
			cyc_q <= 32'h00000000;
			done_q <= 1'b0;
		end else begin
			case (st_q)
			ST_CFG: begin
				cyc_q <= cyc_q + 32'h00000001;
				if (cyc_q >= CFG_CYC) begin
					if (self_test_fail) begin
						st_q <= ST_FAIL;
					end else begin
						st_q <= ST_RUN;
						done_q <= 1'b1;
					end
				end
			end
			ST_RUN: st_q <= ST_RUN;
			ST_FAIL: st_q <= ST_FAIL;
			default: st_q <= ST_CFG;
			endcase
		end
	end

	rio_flasher #(
		.BASE (`RIO_FLASH_BASE)
	) u_flash (
		.pclk     (pclk),
		.presetn  (presetn),
		.baud_sel (baud_sel),
		.run      (st_q != ST_RUN),
		.led      (run_led)
	);
	assign red_led = run_led;

	rio_chain u_ch0 (
		.pclk    (pclk),
		.presetn (presetn),
		.enable  (chain_en[0]),
		.term_ok (chain_term_ok[0]),
		.active  (act_q[0]),
		.led     (green_led[0]),
		.fault   (chain_fault[0])
	);
	rio_chain u_ch1 (
		.pclk    (pclk),
		.presetn (presetn),
		.enable  (chain_en[1]),
		.term_ok (chain_term_ok[1]),
		.active  (act_q[1]),
		.led     (green_led[1]),
		.fault   (chain_fault[1])
	);

	// apb slave
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= 32'h00000000;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			wait_q <= 2'h0;
			page_q <= 2'h0;
			tx_q <= 8'h00;
			act_q <= 2'h0;
		end else begin
			act_q <= (st_q != ST_FAIL && mode_on) ? chain_en : 2'h0;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			if (psel && penable && !pready_q) begin
				if (!hit) begin
					pready_q <= 1'b1;
					pslverr_q <= 1'b1;
					prdata_q <= 32'h00000000;
				end else if (ack_ok) begin
					if (wait_q == `RIO_ACK_DLY) begin
						pready_q <= 1'b1;
						wait_q <= 2'h0;
						if (pwrite) begin
							if (psel_pg) begin
								page_q <= pwdata[1:0];
							end else if (!diag) begin
								out_mem[idx] <= pwdata[7:0];
								tx_q <= pwdata[7:0];
							end
							prdata_q <= 32'h00000000;
						end else if (diag) begin
							prdata_q <= {24'h000000, 1'b0,
								!mode_on, 6'h00};
						end else if (psel_pg) begin
							prdata_q <= {30'h00000000, page_q};
						end else begin
							prdata_q <= {24'h000000, in_mem[idx]};
						end
					end else begin
						wait_q <= wait_q + 2'h1;
					end
				end
			end else begin
				wait_q <= 2'h0;
			end
		end
	end

	always @(posedge pclk) begin
		if (!mode_on && (st_q == ST_RUN)) begin
			in_mem[idx] <= 8'h00;
		end else begin
			in_mem[idx] <= out_mem[idx];
		end
	end
endmodule // rio_top

// ==== verification/rio_sva.sv ====
`timescale 1ns/10ps
module rio_sva (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic [31:0] paddr,
	input wire logic        indirect_op,
	input wire logic        mode_on,
	input wire logic        ack_timeout_mode,
	input wire logic [1:0]  chain_en,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic [1:0]  green_led,
	input wire logic        cfg_done
);
	wire [7:0] ar = paddr[15:8];
	wire um = !(ar == 8'hF0 || ar == 8'hF1 ||
		(ar[7:1] == 7'h7E && indirect_op));
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_err_ready:
	assert property (pslverr |-> pready) else $error("stray error");
	a_ready_pulse:
	assert property (pready |=> !pready) else $error("long ready");
	a_unmapped_fast:
	assert property (psel && $rose(penable) && um |=> pready && pslverr)
		else $error("slow refusal");
	a_mapped_waits:
	assert property (psel && $rose(penable) && !um |=> !pready)
		else $error("early ack");
	a_offline_block:
	assert property (ack_timeout_mode && !mode_on && !um |-> !pready)
		else $error("ack while offline");
	a_unconf_block:
	assert property (!cfg_done && !um |-> !pready) else $error("ack early");
	a_green_follows:
	assert property (1 |=> green_led == $past(chain_en)) else $error("green");
	a_cfg_sticks:
	assert property (cfg_done |=> cfg_done) else $error("cfg lost");
endmodule // rio_sva
bind rio_top rio_sva u_sva (.pclk, .presetn, .psel, .penable, .paddr,
	.indirect_op, .mode_on, .ack_timeout_mode, .chain_en, .pready,
	.pslverr, .green_led, .cfg_done);

// ==== verification/rio_host.sv ====
`timescale 1ns/10ps
module rio_host (
	input wire logic        pclk,
	output logic            psel,
	output logic            penable,
	output logic            pwrite,
	output logic [31:0]     paddr,
	output logic [31:0]     pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr
);
	initial {psel, penable, pwrite, paddr, pwdata} = '0;
	// host cycle; a withheld ack ends as a time-out, r = 0
	task automatic xfer(input logic w, input logic [15:0] a,
		input logic [7:0] d, output logic [9:0] r);
		int n = 0;
		{psel, pwrite, paddr, pwdata} <= {1'b1, w, 16'h0000, a, 24'h000000, d};
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1 && ++n < 20);
		r = pready === 1'b1 ? {1'b1, pslverr, prdata[7:0]} : 10'h000;
		{psel, penable} <= 2'b00;
	endtask
endmodule // rio_host

// ==== verification/tb.sv ====
`timescale 1ns/10ps
module tb;
	logic pclk = 0, presetn = 0, indirect_op = 0, mode_on = 1;
	logic ack_timeout_mode = 0, self_test_fail = 0, mod_present = 1;
	logic [1:0] chain_en = 2'h3, chain_term_ok = 2'h3;
	logic [9:0] r;
	wire psel, penable, pwrite, pready, pslverr, red_led, cfg_done;
	wire [31:0] paddr, pwdata, prdata;
	wire [7:0] chain_tx;
	wire [1:0] chain_active, green_led, chain_fault;
	int fail_count = 0, n_compared = 0, cyc = 0;
	always #20 pclk = ~pclk;
	rio_top #(.CFG_CYC(40)) DUT (.pclk, .presetn, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .indirect_op,
		.page_area_sel(6'h00), .diag_addr_sel(8'h10), .baud_sel(2'h0),
		.mode_on, .ack_timeout_mode, .chain_en, .chain_term_ok,
		.self_test_fail, .mod_present, .chain_tx, .chain_active, .red_led,
		.green_led, .chain_fault, .cfg_done);
	rio_host H (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr);
	task chk(input logic [9:0] got, input logic [9:0] exp);
		n_compared++;
		if (got !== exp) begin
			fail_count++;
			$display("Error %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	task tally_and_finish;
		$display("compared %0d failed %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task io(input logic w, input logic [15:0] a, input logic [7:0] d);
		@(posedge pclk);
		H.xfer(w, a, d, r);
	endtask
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 6000) begin
			fail_count++;
			tally_and_finish;
		end
	end
	task t_unconf;
		io(0, 16'hF005, 8'h00);
		chk(r, 10'h000);
		repeat (60) if (cfg_done !== 1'b1) @(posedge pclk);
		chk({9'h000, cfg_done}, 10'h001);
		@(posedge pclk);
		chk({8'h00, red_led, cfg_done}, 10'h001);
		$display("t_unconf done");
	endtask
	task t_areas;
		logic [7:0] ar [4] = '{8'hF0, 8'hF1, 8'hFC, 8'hFD};
		indirect_op <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			io(1, {ar[i], 8'h05}, 8'h5A ^ ar[i]);
			chk(r & 10'h300, 10'h200);
			io(0, {ar[i], 8'h05}, 8'h00);
			chk(r, {2'b10, 8'h5A ^ ar[i]});
			chk({2'b00, chain_tx}, {2'b00, 8'h5A ^ ar[i]});
		end
		indirect_op <= 1'b0;
		io(0, 16'hFC05, 8'h00);
		chk(r, 10'h300);
		io(0, 16'hF205, 8'h00);
		chk(r, 10'h300);
		$display("t_areas done");
	endtask
	task t_mode;
		io(0, 16'hF010, 8'h00);
		chk(r & 10'h340, 10'h200);
		mode_on <= 1'b0;
		io(0, 16'hF010, 8'h00);
		chk(r & 10'h340, 10'h240);
		chk({8'h00, chain_active}, 10'h000);
		io(0, 16'hF005, 8'h00);
		chk(r, 10'h200);
		ack_timeout_mode <= 1'b1;
		io(0, 16'hF005, 8'h00);
		chk(r, 10'h000);
		mode_on <= 1'b1;
		mod_present <= 1'b0;
		io(0, 16'hF005, 8'h00);
		chk(r, 10'h000);
		{ack_timeout_mode, mod_present} <= 2'b01;
		$display("t_mode done");
	endtask
	task t_chain;
		chain_term_ok <= 2'b10;
		io(0, 16'hF005, 8'h00);
		chk(r, 10'h000);
		chk({8'h00, chain_fault}, 10'h001);
		chain_en <= 2'b10;
		io(0, 16'hF005, 8'h00);
		chk(r & 10'h300, 10'h200);
		chk({8'h00, green_led}, 10'h002);
		chk({8'h00, chain_fault}, 10'h000);
		$display("t_chain done");
	endtask
	task t_fail;
		presetn <= 1'b0;
		self_test_fail <= 1'b1;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		repeat (4200) @(posedge pclk);
		chk({8'h00, red_led, cfg_done}, 10'h002);
		chk({8'h00, chain_active}, 10'h000);
		$display("t_fail done");
	endtask
	initial begin
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		t_unconf;
		t_areas;
		t_mode;
		t_chain;
		t_fail;
		tally_and_finish;
	end
endmodule // tb
